// ===== cfps_col_latch.sv
`timescale 1ns/1ps
`default_nettype none
module cfps_col_latch
  import cfps_pkg::*;
#(
  parameter int unsigned DEPTH = PAGE_BYTES
)
(
  input wire logic i_clk, // Core clock
  input wire logic i_rst_n, // Synchronised reset, active low
  input wire logic i_load, // Load one byte
  input wire logic [IDX_W-1:0] i_load_idx, // Byte in page
  input wire logic [7:0] i_load_data, // Byte to stage
  input wire logic i_clear, // Mark all entries consumed
  input wire logic [IDX_W-1:0] i_rd_idx, // Read index
  output logic [7:0] o_rd_data, // Staged byte
  output logic o_rd_valid // Entry holds fresh data
);

  typedef struct packed
  {
    logic [DEPTH-1:0] valid;
  } cfps_latch_state_t;

  cfps_latch_state_t s_reg;
  cfps_latch_state_t s_next;
  logic [7:0] mem [DEPTH];

  always_comb
  begin
    s_next = s_reg;
    if (i_clear)
    begin
      s_next.valid = '0;
    end
    else if (i_load)
    begin
      s_next.valid[i_load_idx] = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_load && !i_clear)
    begin
      mem[i_load_idx] <= i_load_data;
    end
  end

  assign o_rd_data = mem[i_rd_idx];
  assign o_rd_valid = s_reg.valid[i_rd_idx];

endmodule
`default_nettype wire

// ===== cfps_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module cfps_core_model
(
  input wire logic i_clk, // Clock
  input wire logic i_rst_n, // Reset
  input wire logic i_run_boot, // Code runs from boot
  output logic o_fetch_boot // Fetch source flag
);
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_fetch_boot <= 1'b0;
    else
      o_fetch_boot <= i_run_boot;
  end
endmodule
`default_nettype wire

// ===== cfps_pkg.sv
package cfps_pkg;

  // Memory geometry
  localparam int unsigned PAGE_BYTES = 128;
  localparam int unsigned PAGE_COUNT = 128;
  localparam int unsigned USER_BYTES = PAGE_BYTES * PAGE_COUNT;
  localparam int unsigned BOOT_BYTES = 2048;
  localparam int unsigned IDX_W = 7;
  localparam int unsigned PAGE_W = 7;
  localparam int unsigned USER_AW = 14;
  localparam int unsigned BOOT_AW = 11;

  // Code space windows
  localparam logic [15:0] USER_LO = 16'h0000;
  localparam logic [15:0] USER_HI = 16'h3fff;
  localparam logic [15:0] BOOT_LO = 16'hf800;
  localparam logic [15:0] EXTRA_ROW_SPACE_LO = 16'hff80;

  // Key bytes
  localparam logic [7:0] KEY_USER_1 = 8'h50;
  localparam logic [7:0] KEY_USER_2 = 8'ha0;
  localparam logic [7:0] KEY_EXTRA_ROW_SPACE_1 = 8'h52;
  localparam logic [7:0] KEY_EXTRA_ROW_SPACE_2 = 8'ha2;
  localparam logic [7:0] KEY_SEC_1 = 8'h54;
  localparam logic [7:0] KEY_SEC_2 = 8'ha4;

  // Register byte offsets
  localparam logic [7:0] OFS_AUX_CTRL = 8'h00;
  localparam logic [7:0] OFS_FLASH_CTRL = 8'h04;
  localparam logic [7:0] OFS_LATCH_LOAD = 8'h08;
  localparam logic [7:0] OFS_CODE_ADDR = 8'h0c;
  localparam logic [7:0] OFS_CODE_DATA = 8'h10;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h18;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h1c;

  // Field positions
  localparam int unsigned BIT_BOOT_MAP = 0;
  localparam int unsigned BIT_BUSY = 0;
  localparam int unsigned BIT_ARMED = 1;
  localparam int unsigned BIT_IRQ_DONE = 0;
  localparam int unsigned BIT_IRQ_REFUSED = 1;
  localparam int unsigned IRQ_W = 2;

  // Code read space select in CODE_ADDR[17:16]
  localparam logic [1:0] SPACE_CODE = 2'h0;
  localparam logic [1:0] SPACE_EXTRA_ROW_SPACE = 2'h1;
  localparam logic [1:0] SPACE_SEC = 2'h2;

  // Page write time
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned PROG_TIME_US = 5000;
  localparam int unsigned PROG_CYCLES_DEF = (PROG_TIME_US * 1000 +
    CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 20;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_KEY = 2'b01,
    ST_PROG = 2'b11,
    ST_WAIT = 2'b10
  } cfps_state_t;

  typedef enum logic [1:0]
  {
    TGT_USER = 2'h0,
    TGT_EXTRA_ROW_SPACE = 2'h1,
    TGT_SEC = 2'h2
  } cfps_target_t;

endpackage

// ===== cfps_top.sv
`timescale 1ns/1ps
`default_nettype none
module cfps_top
  import cfps_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_CYCLES_DEF
)
(
  input wire logic i_clk, // Core clock
  input wire logic i_reset_n, // Async reset, active low
  input wire logic [7:0] i_avs_address, // Byte address
  input wire logic i_avs_read, // Read request
  input wire logic i_avs_write, // Write request
  input wire logic [31:0] i_avs_writedata, // Write data
  input wire logic [3:0] i_avs_byteenable, // Byte lanes
  output logic [31:0] o_avs_readdata, // Read data
  output logic o_avs_waitrequest, // Stall
  input wire logic i_fetch_boot, // Core fetching from boot flash
  input wire logic i_par_boot_we, // Parallel boot flash write
  input wire logic i_par_sec_we, // Parallel security low write
  input wire logic [BOOT_AW-1:0] i_par_addr, // Parallel address
  input wire logic [7:0] i_par_data, // Parallel data
  output logic o_boot_map_enable, // Boot flash mapped
  output logic o_flash_busy_flag, // Programming in progress
  output logic o_irq // Interrupt, active high
);

  typedef struct packed
  {
    cfps_state_t st;
    cfps_target_t tgt;
    logic ack;
    logic [31:0] rdata;
    logic boot_map;
    logic [PAGE_W-1:0] page;
    logic [IDX_W-1:0] idx;
    logic [CNT_W-1:0] cnt;
    logic [17:0] code_addr;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_en;
    logic [3:0] sec_hi;
    logic [3:0] sec_lo;
  } cfps_top_state_t;

  localparam logic [CNT_W-1:0] PROG_LAST = CNT_W'(PROG_CYCLES - 1);
  localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(PAGE_BYTES - 1);

  cfps_top_state_t s_reg;
  cfps_top_state_t s_next;
  logic rst_meta_reg;
  logic rst_n_reg;

  logic [7:0] user_mem [USER_BYTES];
  logic [7:0] extra_row_space_mem [PAGE_BYTES];
  logic [7:0] boot_mem [BOOT_BYTES];

  logic req;
  logic wr;
  logic rd;
  logic user_we;
  logic extra_row_space_we;
  logic lat_load;
  logic lat_clear;
  logic [IDX_W-1:0] lat_load_idx;
  logic [7:0] lat_data;
  logic lat_valid;
  logic [IRQ_W-1:0] irq_set;

  function automatic logic [7:0] code_read(input logic [17:0] a,
    input logic map);
    logic [15:0] ca;
    ca = a[15:0];
    code_read = 8'h00;
    unique case (a[17:16])
      SPACE_EXTRA_ROW_SPACE: code_read = extra_row_space_mem[ca[IDX_W-1:0]];
      SPACE_SEC: code_read = {s_reg.sec_hi, s_reg.sec_lo};
      SPACE_CODE:
      begin
        if (map && ca >= BOOT_LO)
        begin
          code_read = boot_mem[ca[BOOT_AW-1:0]];
        end
        else if (ca <= USER_HI)
        begin
          code_read = user_mem[ca[USER_AW-1:0]];
        end
      end
      default: code_read = 8'h00;
    endcase
  endfunction

  function automatic logic second_key(input cfps_target_t t,
    input logic [7:0] d);
    unique case (t)
      TGT_USER: second_key = (d == KEY_USER_2);
      TGT_EXTRA_ROW_SPACE: second_key = (d == KEY_EXTRA_ROW_SPACE_2);
      TGT_SEC: second_key = (d == KEY_SEC_2);
      default: second_key = 1'b0;
    endcase
  endfunction

  // Reset release
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  cfps_col_latch #(
    .DEPTH(PAGE_BYTES)
  ) u_latch (
    .i_clk(i_clk),
    .i_rst_n(rst_n_reg),
    .i_load(lat_load),
    .i_load_idx(lat_load_idx),
    .i_load_data(i_avs_writedata[23:16]),
    .i_clear(lat_clear),
    .i_rd_idx(s_reg.idx),
    .o_rd_data(lat_data),
    .o_rd_valid(lat_valid)
  );

  assign req = i_avs_read | i_avs_write;
  assign wr = i_avs_write & s_reg.ack;
  assign rd = i_avs_read & ~s_reg.ack;
  assign lat_load_idx = i_avs_writedata[IDX_W-1:0];

  always_comb
  begin
    s_next = s_reg;
    user_we = 1'b0;
    extra_row_space_we = 1'b0;
    lat_load = 1'b0;
    lat_clear = 1'b0;
    irq_set = '0;
    s_next.ack = req & ~s_reg.ack;

    if (rd)
    begin
      s_next.rdata = '0;
      unique case (i_avs_address)
        OFS_AUX_CTRL: s_next.rdata[BIT_BOOT_MAP] = s_reg.boot_map;
        OFS_FLASH_CTRL:
        begin
          s_next.rdata[BIT_BUSY] = o_flash_busy_flag;
          s_next.rdata[BIT_ARMED] = (s_reg.st == ST_KEY);
        end
        OFS_CODE_ADDR: s_next.rdata[17:0] = s_reg.code_addr;
        OFS_CODE_DATA:
          s_next.rdata[7:0] = code_read(s_reg.code_addr, s_reg.boot_map);
        OFS_IRQ_STATUS: s_next.rdata[IRQ_W-1:0] = s_reg.irq_st;
        OFS_IRQ_ENABLE: s_next.rdata[IRQ_W-1:0] = s_reg.irq_en;
        default: s_next.rdata = '0;
      endcase
    end

    if (wr && i_avs_byteenable[0])
    begin
      unique case (i_avs_address)
        OFS_AUX_CTRL: s_next.boot_map = i_avs_writedata[BIT_BOOT_MAP];
        OFS_CODE_ADDR:
          if (i_avs_byteenable[2:0] == 3'h7)
          begin
            s_next.code_addr = i_avs_writedata[17:0];
          end
        OFS_LATCH_LOAD:
          // Loads accepted only when not busy (idle or armed) and in the user or extra row window
          if (i_avs_byteenable[2:0] == 3'h7 && !o_flash_busy_flag)
          begin
            if (i_avs_writedata[15:0] <= USER_HI)
            begin
              lat_load = 1'b1;
              s_next.page = i_avs_writedata[USER_AW-1:IDX_W];
            end
            else if (i_avs_writedata[15:0] >= EXTRA_ROW_SPACE_LO)
            begin
              lat_load = 1'b1;
            end
          end
        OFS_IRQ_ENABLE: s_next.irq_en = i_avs_writedata[IRQ_W-1:0];
        default:
        begin
        end
      endcase
    end

    if (wr && i_avs_byteenable[3:0] == 4'hf
        && i_avs_address == OFS_IRQ_CLEAR)
    begin
      s_next.irq_st = s_reg.irq_st & ~i_avs_writedata[IRQ_W-1:0];
    end

    unique case (s_reg.st)
      ST_IDLE:
        if (wr && i_avs_byteenable[0] && i_avs_address == OFS_FLASH_CTRL)
        begin
          if (!i_fetch_boot)
          begin
            irq_set[BIT_IRQ_REFUSED] = 1'b1;
          end
          else if (i_avs_writedata[7:0] == KEY_USER_1)
          begin
            s_next.tgt = TGT_USER;
            s_next.st = ST_KEY;
          end
          else if (i_avs_writedata[7:0] == KEY_EXTRA_ROW_SPACE_1)
          begin
            s_next.tgt = TGT_EXTRA_ROW_SPACE;
            s_next.st = ST_KEY;
          end
          else if (i_avs_writedata[7:0] == KEY_SEC_1)
          begin
            s_next.tgt = TGT_SEC;
            s_next.st = ST_KEY;
          end
        end
      ST_KEY:
        if (wr && i_avs_byteenable[0] && i_avs_address == OFS_FLASH_CTRL)
        begin
          s_next.st = ST_IDLE;
          s_next.idx = '0;
          if (!i_fetch_boot)
          begin
            irq_set[BIT_IRQ_REFUSED] = 1'b1;
          end
          else if (second_key(s_reg.tgt, i_avs_writedata[7:0]))
          begin
            s_next.st = ST_PROG;
          end
        end
      ST_PROG:
      begin
        // One staged byte per cycle; unloaded entries left as they are
        if (lat_valid)
        begin
          unique case (s_reg.tgt)
            TGT_USER: user_we = 1'b1;
            TGT_EXTRA_ROW_SPACE: extra_row_space_we = 1'b1;
            TGT_SEC:
              if (s_reg.idx == '0)
              begin
                s_next.sec_hi = lat_data[7:4];
              end
            default:
            begin
            end
          endcase
        end
        s_next.idx = s_reg.idx + 1'b1;
        if (s_reg.idx == IDX_LAST)
        begin
          s_next.st = ST_WAIT;
          s_next.cnt = '0;
        end
      end
      ST_WAIT:
      begin
        s_next.cnt = s_reg.cnt + 1'b1;
        if (s_reg.cnt == PROG_LAST)
        begin
          s_next.st = ST_IDLE;
          lat_clear = 1'b1;
          irq_set[BIT_IRQ_DONE] = 1'b1;
        end
      end
    endcase

    if (i_par_sec_we)
    begin
      s_next.sec_lo = i_par_data[3:0];
    end

    // New events win over a clear in the same cycle
    s_next.irq_st = s_next.irq_st | irq_set;
  end

  always_ff @(posedge i_clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (user_we)
    begin
      user_mem[{s_reg.page, s_reg.idx}] <= lat_data;
    end
    if (extra_row_space_we)
    begin
      extra_row_space_mem[s_reg.idx] <= lat_data;
    end
    if (i_par_boot_we)
    begin
      boot_mem[i_par_addr] <= i_par_data;
    end
  end

  assign o_avs_waitrequest = req & ~s_reg.ack;
  assign o_avs_readdata = s_reg.rdata;
  assign o_boot_map_enable = s_reg.boot_map;
  assign o_flash_busy_flag = (s_reg.st == ST_PROG) ||
    (s_reg.st == ST_WAIT);
  assign o_irq = |(s_reg.irq_st & s_reg.irq_en);

endmodule
`default_nettype wire

// ===== cfps_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module cfps_top_monitor
  import cfps_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = 8
)
(
  input wire logic i_clk, // Clock
  input wire logic i_reset_n, // Reset
  input wire logic [7:0] i_avs_address, // Address
  input wire logic i_avs_read, // Read
  input wire logic i_avs_write, // Write
  input wire logic [31:0] i_avs_writedata, // Data in
  input wire logic [3:0] i_avs_byteenable, // Lanes
  input wire logic [31:0] o_avs_readdata, // Data out
  input wire logic o_avs_waitrequest, // Stall
  input wire logic i_fetch_boot, // Boot fetch
  input wire logic o_boot_map_enable, // Boot map
  input wire logic o_flash_busy_flag // Busy
);
  logic wr_take;
  logic key_two;
  logic [31:0] busy_cnt;
  assign wr_take = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
  assign key_two = wr_take && i_fetch_boot &&
    i_avs_address == OFS_FLASH_CTRL &&
    i_avs_writedata[7:0] inside {KEY_USER_2, KEY_EXTRA_ROW_SPACE_2, KEY_SEC_2};
  // Length of the current busy span
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      busy_cnt <= 32'h0;
    else if (o_flash_busy_flag)
      busy_cnt <= busy_cnt + 32'h1;
    else
      busy_cnt <= 32'h0;
  end
  default clocking mon_cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  sequence s_aux_wr;
    wr_take && i_avs_address == OFS_AUX_CTRL;
  endsequence
  sequence s_key_off_boot;
    wr_take && !i_fetch_boot && i_avs_address == OFS_FLASH_CTRL;
  endsequence
  a_wait_single:
    assert property (o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("wait state longer than one cycle");
  a_wait_first:
    assert property ($rose(i_avs_read || i_avs_write) |-> o_avs_waitrequest)
    else $error("request answered without wait state");
  a_read_hold:
    assert property (!i_avs_read |=> $stable(o_avs_readdata))
    else $error("read data changed without a read");
  a_unmapped_zero:
    assert property (i_avs_read && !o_avs_waitrequest &&
      i_avs_address > OFS_IRQ_CLEAR |-> o_avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_map_load:
    assert property (s_aux_wr |=> o_boot_map_enable == $past(i_avs_writedata[0]))
    else $error("boot map bit not loaded");
  a_map_hold:
    assert property (!(wr_take && i_avs_address == OFS_AUX_CTRL)
      |=> $stable(o_boot_map_enable))
    else $error("boot map changed without write");
  a_busy_cause:
    assert property ($rose(o_flash_busy_flag) |-> $past(key_two))
    else $error("busy rose without second key");
  a_key_off_boot:
    assert property (s_key_off_boot |=> !$rose(o_flash_busy_flag))
    else $error("programming started off boot code");
  a_busy_span:
    assert property ($fell(o_flash_busy_flag) |-> busy_cnt == 128 + PROG_CYCLES)
    else $error("busy span wrong length");
  a_busy_bound:
    assert property (o_flash_busy_flag |-> busy_cnt < 128 + PROG_CYCLES)
    else $error("busy held too long");
endmodule
bind cfps_top cfps_top_monitor #(.PROG_CYCLES(PROG_CYCLES)) u_mon
(
  .i_clk(i_clk),
  .i_reset_n(i_reset_n),
  .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata),
  .i_avs_byteenable(i_avs_byteenable),
  .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest),
  .i_fetch_boot(i_fetch_boot),
  .o_boot_map_enable(o_boot_map_enable),
  .o_flash_busy_flag(o_flash_busy_flag)
);
`default_nettype wire

// ===== test_code_flash_program_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module test_code_flash_program_sequencer;
  import cfps_pkg::*;
  logic i_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0] be = 4'hf;
  logic boot = 1'b0;
  logic bwe = 1'b0;
  logic swe = 1'b0;
  logic [10:0] pa = 11'h0;
  logic [7:0] pd = 8'h0;
  logic [31:0] rdat;
  logic wreq;
  logic fetch;
  logic map;
  logic busy;
  logic irq;
  logic [31:0] q;
  logic [7:0] dat [4];
  logic [7:0] bb;
  logic [6:0] pg;
  integer seed;
  int err_total = 0;
  int checked = 0;
  always #50 i_clk = ~i_clk;
  cfps_core_model core
  (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_run_boot(boot),
    .o_fetch_boot(fetch)
  );
  cfps_top #(.PROG_CYCLES(8)) dut
  (
    .i_clk(i_clk),
    .i_reset_n(rst_n),
    .i_avs_address(adr),
    .i_avs_read(rd),
    .i_avs_write(wr),
    .i_avs_writedata(wd),
    .i_avs_byteenable(be),
    .o_avs_readdata(rdat),
    .o_avs_waitrequest(wreq),
    .i_fetch_boot(fetch),
    .i_par_boot_we(bwe),
    .i_par_sec_we(swe),
    .i_par_addr(pa),
    .i_par_data(pd),
    .o_boot_map_enable(map),
    .o_flash_busy_flag(busy),
    .o_irq(irq)
  );
  function automatic logic [31:0] ldw(input logic [15:0] a, logic [7:0] d);
    return {8'h00, d, a};
  endfunction
  function automatic logic [6:0] idx(input int i);
    return (i == 3) ? 7'h7f : 7'(i * 42);
  endfunction
  task automatic chk(input string nm, logic [31:0] got, logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic bus(input logic w, logic [7:0] a, logic [31:0] d);
    int n;
    logic wt;
    n = 0;
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do
    begin
      @(negedge i_clk);
      wt = wreq;
      q = rdat;
      @(posedge i_clk);
      n++;
    end
    while (wt !== 1'b0 && n < 20);
    chk("ack", {31'h0, wt}, 32'h0);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic code(input logic [1:0] s, logic [15:0] a);
    bus(1'b1, OFS_CODE_ADDR, {14'h0, s, a});
    bus(1'b0, OFS_CODE_DATA, 32'h0);
  endtask
  task automatic launch(input logic [7:0] k1, logic [7:0] k2, logic b);
    logic [31:0] en;
    boot <= b;
    bus(1'b0, OFS_IRQ_ENABLE, 32'h0);
    en = q;
    bus(1'b1, OFS_IRQ_ENABLE, 32'h0);
    bus(1'b1, OFS_FLASH_CTRL, {24'h0, k1});
    bus(1'b1, OFS_FLASH_CTRL, {24'h0, k2});
    bus(1'b0, OFS_FLASH_CTRL, 32'h0);
    chk("busy_on", q & 32'h1, {31'h0, b});
    for (int n = 0; n < 100 && q[0] !== 1'b0; n++)
      bus(1'b0, OFS_FLASH_CTRL, 32'h0);
    chk("busy_end", q & 32'h1, 32'h0);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    bus(1'b1, OFS_IRQ_ENABLE, en);
  endtask
  initial
  begin
    repeat (20000) @(posedge i_clk);
    err_total++;
    tally_and_finish;
  end
  initial
  begin
    seed = 32'ha8d9a02e;
    repeat (5) @(posedge i_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    bus(1'b0, OFS_AUX_CTRL, 32'h0);
    chk("aux_rst", q, 32'h0);
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped", q, 32'h0);
    code(SPACE_SEC, 16'h0);
    chk("sec_rst", q, 32'h0);
    $display("reset test done");
    pa <= 11'($random(seed));
    bb = 8'($random(seed));
    pd <= bb;
    bwe <= 1'b1;
    @(posedge i_clk);
    bwe <= 1'b0;
    bus(1'b1, OFS_AUX_CTRL, 32'h1);
    chk("map_pin", {31'h0, map}, 32'h1);
    code(SPACE_CODE, BOOT_LO + 16'(pa));
    chk("boot_rd", q, {24'h0, bb});
    bus(1'b1, OFS_LATCH_LOAD, ldw(BOOT_LO + 16'(pa), ~bb));
    $display("boot map test done");
    bus(1'b1, OFS_IRQ_ENABLE, 32'h3);
    pg = 7'($random(seed));
    bus(1'b1, OFS_LATCH_LOAD, ldw({2'b00, ~pg, 7'h01}, 8'h5a));
    for (int i = 0; i < 4; i++)
    begin
      dat[i] = 8'($random(seed));
      bus(1'b1, OFS_LATCH_LOAD, ldw({2'b00, pg, idx(i)}, dat[i]));
    end
    launch(KEY_USER_1, KEY_USER_2, 1'b0);
    bus(1'b0, OFS_IRQ_STATUS, 32'h0);
    chk("refused", q, 32'h2);
    chk("irq_set", {31'h0, irq}, 32'h1);
    bus(1'b1, OFS_IRQ_CLEAR, 32'h3);
    chk("irq_clr", {31'h0, irq}, 32'h0);
    launch(KEY_USER_1, KEY_USER_2, 1'b1);
    bus(1'b0, OFS_IRQ_STATUS, 32'h0);
    chk("done", q, 32'h1);
    bus(1'b1, OFS_IRQ_ENABLE, 32'h2);
    chk("irq_mask", {31'h0, irq}, 32'h0);
    bus(1'b1, OFS_IRQ_ENABLE, 32'h3);
    chk("irq_unmask", {31'h0, irq}, 32'h1);
    bus(1'b1, OFS_IRQ_CLEAR, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      code(SPACE_CODE, {2'b00, pg, idx(i)});
      chk("user_byte", q, {24'h0, dat[i]});
    end
    code(SPACE_CODE, {2'b00, pg, 7'h01});
    chk("last_page", q, 32'h5a);
    $display("user program test done");
    bus(1'b1, OFS_FLASH_CTRL, {24'h0, KEY_USER_1});
    bus(1'b0, OFS_FLASH_CTRL, 32'h0);
    chk("armed", q, 32'h2);
    bus(1'b1, OFS_FLASH_CTRL, {24'h0, KEY_EXTRA_ROW_SPACE_1});
    bus(1'b1, OFS_FLASH_CTRL, {24'h0, KEY_USER_2});
    bus(1'b0, OFS_FLASH_CTRL, 32'h0);
    chk("broken", q, 32'h0);
    $display("broken key test done");
    for (int i = 0; i < 4; i += 3)
      bus(1'b1, OFS_LATCH_LOAD, ldw(EXTRA_ROW_SPACE_LO + 16'(idx(i)), ~dat[i]));
    launch(KEY_EXTRA_ROW_SPACE_1, KEY_EXTRA_ROW_SPACE_2, 1'b1);
    for (int i = 0; i < 4; i += 3)
    begin
      code(SPACE_EXTRA_ROW_SPACE, EXTRA_ROW_SPACE_LO + 16'(idx(i)));
      chk("extra_row_space_byte", q, {24'h0, ~dat[i]});
    end
    code(SPACE_CODE, BOOT_LO + 16'(pa));
    chk("boot_kept", q, {24'h0, bb});
    launch(KEY_USER_1, KEY_USER_2, 1'b1);
    code(SPACE_CODE, {2'b00, pg, idx(0)});
    chk("consumed", q, {24'h0, dat[0]});
    $display("extra row test done");
    bus(1'b1, OFS_LATCH_LOAD, ldw(16'h0000, dat[1]));
    launch(KEY_SEC_1, KEY_SEC_2, 1'b1);
    pd <= dat[2];
    swe <= 1'b1;
    @(posedge i_clk);
    swe <= 1'b0;
    code(SPACE_SEC, 16'h0);
    chk("sec_byte", q, {24'h0, dat[1][7:4], dat[2][3:0]});
    bus(1'b0, OFS_CODE_ADDR, 32'h0);
    chk("code_addr", q, {14'h0, SPACE_SEC, 16'h0});
    be <= 4'he;
    bus(1'b1, OFS_AUX_CTRL, 32'h0);
    be <= 4'hf;
    chk("map_lane", {31'h0, map}, 32'h1);
    bus(1'b1, OFS_AUX_CTRL, 32'h0);
    chk("map_off", {31'h0, map}, 32'h0);
    $display("security test done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
